// [src/codec_pkg.sv]
// Purpose: shared constants and types of the codec clock and peak core
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes:   control word is 16 bits, upper bits read as zero
package codec_pkg;
	localparam int CTRL_W = 16;
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_PEAK0  = 8'h08;
	localparam logic [7:0] ADDR_PEAK1  = 8'h0C;
	localparam logic [7:0] ADDR_ATTEN0 = 8'h10;
	localparam logic [7:0] ADDR_ATTEN7 = 8'h2C;
	// scaler codes
	localparam logic [1:0] SCALE_X1  = 2'h0;
	localparam logic [1:0] SCALE_X2  = 2'h1;
	localparam logic [1:0] SCALE_X23 = 2'h2;
	// mclk step in thirds of an engine tick
	localparam logic [4:0] STEP_X1  = 5'h03;
	localparam logic [4:0] STEP_X2  = 5'h06;
	localparam logic [4:0] STEP_X23 = 5'h02;
	// half bit-clock period in thirds of an engine tick
	localparam logic [4:0] HALF_48 = 5'h0C;
	localparam logic [4:0] HALF_96 = 5'h06;
	localparam logic [4:0] BITS_PER_HALF = 5'h1F;
	localparam logic [7:0] OSR_48 = 8'h80;
	localparam logic [7:0] OSR_96 = 8'h40;
	// word widths
	localparam logic [1:0] WID_16 = 2'h0;
	localparam logic [1:0] WID_20 = 2'h1;
	localparam logic [1:0] WID_24 = 2'h2;
	localparam logic [1:0] RATE_48  = 2'h0;
	localparam logic [1:0] RATE_96  = 2'h1;
	localparam logic [1:0] RATE_192 = 2'h2;
	localparam logic [4:0] INIT_FRAMES = 5'h14;
	localparam logic [9:0] ATTEN_RST = 10'h3FF;
	localparam logic [5:0] PEAK_FLOOR = 6'h3F;

	typedef struct packed {
		logic [6:0] rsvd;
		logic       packed_mode;
		logic       replicate;
		logic [1:0] dac_rate;
		logic       adc_96k;
		logic [1:0] width;
		logic [1:0] scaler;
	} ctrl_t;

	localparam ctrl_t CTRL_RST = '{rsvd: 7'h00, packed_mode: 1'b0,
		replicate: 1'b0, dac_rate: RATE_48, adc_96k: 1'b0,
		width: WID_24, scaler: SCALE_X2};
endpackage

// [src/codec_core.sv]
// Purpose: clock scaling, serial clock direction, dac input, peak detect
// Assumes: clock, strap and dac pins are asynchronous to SYS_CLK_I and are synchronised; adc sample pins are used unsynchronised
// Notes:   engine clock is modelled as a tick rate in thirds of a tick
//
// What this block does
// - decimation oversampling is 128 at 48 kHz and 64 at 96 kHz
// - adc sample rate is 48 or 96 kHz, never higher
// - each adc peak reads as 6-bit attenuation, 0 to -63 dB, 1 dB steps
// - peak holds until read; the read restarts acquisition
// - both adc channels share one bit clock and one frame clock
// - adc clock pins are inputs when strapped high, driven outputs when low
// - eight dac channels in four pairs, each with 1024-step attenuator
// - four dac data pins share one dac frame and bit clock
// - packed mode carries all eight dac channels on the first pin
// - stereo replicate copies the first pair to all other pairs
// - 192 kHz input only on the first pair; others via replicate
// - samples are two's complement
// - word width selectable as 16, 20 or 24 bits
// - engines run from 24.576 MHz; adc 48/96, dac 48/96/192 kHz
// - scaler multiplies master clock by 1, 2 or 2/3
// - scaler resets to factor 2
// - control words are 16 bits, asynchronous to the sample rate
// - after reset memories clear for 20 frame periods; writes refused
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module codec_core
	import codec_pkg::*;
#(
	parameter int SW = 24
)(
	input  wire logic           SYS_CLK_I,
	input  wire logic           RST_B_I,
	input  wire logic           PSEL_I,
	input  wire logic           PENABLE_I,
	input  wire logic           PWRITE_I,
	input  wire logic [7:0]     PADDR_I,
	input  wire logic [31:0]    PWDATA_I,
	output logic [31:0]         PRDATA_O,
	output logic                PREADY_O,
	output logic                PSLVERR_O,
	input  wire logic           MCLK_I,
	input  wire logic           ADC_CLK_DIR_I,
	input  wire logic           ADC_BIT_CLOCK_I,
	output logic                ADC_BIT_CLOCK_O,
	output logic                ADC_BIT_CLOCK_OE_O,
	input  wire logic           ADC_FRAME_CLOCK_I,
	output logic                ADC_FRAME_CLOCK_O,
	output logic                ADC_FRAME_CLOCK_OE_O,
	input  wire logic           ADC_VALID_I,
	input  wire logic [SW-1:0]  ADC_LEFT_I,
	input  wire logic [SW-1:0]  ADC_RIGHT_I,
	input  wire logic           DAC_BIT_CLOCK_I,
	input  wire logic           DAC_FRAME_CLOCK_I,
	input  wire logic [3:0]     DAC_PAIR_SERIAL_INPUT_I,
	output logic [8*SW-1:0]     DAC_DATA_O,
	output logic                DAC_VALID_O,
	output logic                INIT_BUSY_O
);
	////////////////////////////////////////////////////////////////////
	// pin synchronisers: stage one is read only by stage two
	localparam int NS = 9;
	logic [NS-1:0] s1_reg;
	logic [NS-1:0] s2_reg;
	logic [NS-1:0] pin_in;
	logic [2:0]    edge_reg;
	assign pin_in = {MCLK_I, ADC_CLK_DIR_I, ADC_BIT_CLOCK_I,
		ADC_FRAME_CLOCK_I, DAC_BIT_CLOCK_I, DAC_FRAME_CLOCK_I,
		DAC_PAIR_SERIAL_INPUT_I[3:1]};
	logic d1_s1_reg;
	logic d1_s2_reg;

	always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
		if (!RST_B_I)
		begin
			s1_reg    <= '0;
			s2_reg    <= '0;
			d1_s1_reg <= 1'b0;
			d1_s2_reg <= 1'b0;
			edge_reg  <= '0;
		end
		else
		begin
			s1_reg    <= pin_in;
			s2_reg    <= s1_reg;
			d1_s1_reg <= DAC_PAIR_SERIAL_INPUT_I[0];
			d1_s2_reg <= d1_s1_reg;
			edge_reg  <= {s2_reg[8], s2_reg[4], s2_reg[3]};
		end

	wire       mclk_s   = s2_reg[8];
	wire       slave    = s2_reg[7];
	wire       dbclk_s  = s2_reg[4];
	wire       dlr_s    = s2_reg[3];
	wire [3:0] dpin_s   = {s2_reg[2:0], d1_s2_reg};
	wire       mclk_ris = mclk_s & ~edge_reg[2];
	wire       dbc_ris  = dbclk_s & ~edge_reg[1];
	wire       dlr_ris  = dlr_s & ~edge_reg[0];

	////////////////////////////////////////////////////////////////////
	// control registers and apb slave
	ctrl_t       ctrl_reg;
	ctrl_t       wr_ctrl;
	logic [9:0]  atten_reg [8];
	logic [5:0]  peak_db_reg [2];
	logic        init_reg;
	logic [4:0]  init_cnt_reg;
	logic        rd_peak0_reg;
	logic        rd_peak1_reg;

	wire setup   = PSEL_I & ~PENABLE_I;
	wire access  = PSEL_I & PENABLE_I;
	wire is_atn  = (PADDR_I >= ADDR_ATTEN0) && (PADDR_I <= ADDR_ATTEN7)
		&& (PADDR_I[1:0] == 2'h0);
	wire [2:0] atn_ix = 3'((PADDR_I - ADDR_ATTEN0) >> 2);
	wire is_ctrl = PADDR_I == ADDR_CTRL;
	wire is_stat = PADDR_I == ADDR_STATUS;
	wire is_pk0  = PADDR_I == ADDR_PEAK0;
	wire is_pk1  = PADDR_I == ADDR_PEAK1;
	wire mapped  = is_ctrl | is_stat | is_pk0 | is_pk1 | is_atn;
	assign wr_ctrl = ctrl_t'(PWDATA_I[CTRL_W-1:0]);
	// reserved codes are refused whole; adc has no rate above 96 kHz
	wire ctrl_bad = (wr_ctrl.scaler == 2'h3) | (wr_ctrl.width == 2'h3)
		| (wr_ctrl.dac_rate == 2'h3);
	wire wr_bad  = ~mapped | is_stat | is_pk0 | is_pk1 | init_reg
		| (is_ctrl & ctrl_bad);
	wire err     = PWRITE_I ? wr_bad : ~mapped;
	wire wr_ok   = access & PWRITE_I & ~PSLVERR_O;
	wire [7:0] osr = ctrl_reg.adc_96k ? OSR_96 : OSR_48;

	logic [31:0] rd_mux;
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		if (is_ctrl)
			rd_mux = {16'h0000, ctrl_reg};
		else if (is_stat)
			rd_mux = {22'h00_0000, osr, ~slave, init_reg};
		else if (is_pk0)
			rd_mux = {26'h000_0000, peak_db_reg[0]};
		else if (is_pk1)
			rd_mux = {26'h000_0000, peak_db_reg[1]};
		else if (is_atn)
			rd_mux = {22'h00_0000, atten_reg[atn_ix]};
	end

	always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
		if (!RST_B_I)
		begin
			PRDATA_O     <= 32'h0000_0000;
			PREADY_O     <= 1'b1;
			PSLVERR_O    <= 1'b0;
			rd_peak0_reg <= 1'b0;
			rd_peak1_reg <= 1'b0;
		end
		else
		begin
			PREADY_O     <= 1'b1;
			PSLVERR_O    <= setup & err;
			PRDATA_O     <= (setup & ~PWRITE_I) ? rd_mux : PRDATA_O;
			rd_peak0_reg <= setup & ~PWRITE_I & is_pk0;
			rd_peak1_reg <= setup & ~PWRITE_I & is_pk1;
		end

	always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
		if (!RST_B_I)
			ctrl_reg <= CTRL_RST;
		else if (wr_ok & is_ctrl)
			ctrl_reg <= wr_ctrl;

	for (genvar a = 0; a < 8; a++)
	begin : g_atn
		always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
			if (!RST_B_I)
				atten_reg[a] <= ATTEN_RST;
			else if (wr_ok & is_atn & (atn_ix == 3'(a)))
				atten_reg[a] <= PWDATA_I[9:0];
	end

	// memories clear while busy; counts dac frame periods
	always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
		if (!RST_B_I)
		begin
			init_reg     <= 1'b1;
			init_cnt_reg <= 5'h00;
		end
		else if (init_reg & dlr_ris)
		begin
			init_cnt_reg <= init_cnt_reg + 5'h01;
			init_reg     <= (init_cnt_reg + 5'h01) != INIT_FRAMES;
		end

	////////////////////////////////////////////////////////////////////
	// engine tick and adc master clocks, counted in thirds of a tick
	logic [4:0] acc_reg;
	logic [4:0] bcnt_reg;
	logic       adc_bit_clock_reg;
	logic       alr_reg;
	wire [4:0] step = (ctrl_reg.scaler == SCALE_X1) ? STEP_X1 :
		(ctrl_reg.scaler == SCALE_X2) ? STEP_X2 : STEP_X23;
	wire [4:0] half = ctrl_reg.adc_96k ? HALF_96 : HALF_48;
	wire [4:0] acc_sum = acc_reg + step;
	wire       toggle  = mclk_ris & (acc_sum >= half);

	always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
		if (!RST_B_I)
		begin
			acc_reg   <= 5'h00;
			bcnt_reg  <= 5'h00;
			adc_bit_clock_reg <= 1'b0;
			alr_reg   <= 1'b0;
		end
		else if (mclk_ris)
		begin
			acc_reg <= toggle ? acc_sum - half : acc_sum;
			if (toggle)
			begin
				adc_bit_clock_reg <= ~adc_bit_clock_reg;
				// frame clock moves on the falling bit-clock edge
				if (adc_bit_clock_reg)
				begin
					bcnt_reg <= bcnt_reg + 5'h01;
					if (bcnt_reg == BITS_PER_HALF)
						alr_reg <= ~alr_reg;
				end
			end
		end

	always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
		if (!RST_B_I)
		begin
			ADC_BIT_CLOCK_O      <= 1'b0;
			ADC_FRAME_CLOCK_O    <= 1'b0;
			ADC_BIT_CLOCK_OE_O   <= 1'b0;
			ADC_FRAME_CLOCK_OE_O <= 1'b0;
		end
		else
		begin
			// strap high leaves the pins to the controller
			ADC_BIT_CLOCK_OE_O   <= ~slave;
			ADC_FRAME_CLOCK_OE_O <= ~slave;
			ADC_BIT_CLOCK_O      <= adc_bit_clock_reg;
			ADC_FRAME_CLOCK_O    <= alr_reg;
		end

	////////////////////////////////////////////////////////////////////
	// peak detectors; a read in flight loses to a new sample
	function automatic logic [5:0] to_db(input logic [SW-2:0] m);
		logic [6:0] db;
		logic [2:0] fr;
		int         p;
		db = 7'(PEAK_FLOOR);
		fr = 3'h0;
		p  = -1;
		for (int i = 0; i < SW - 1; i++)
			if (m[i])
				p = i;
		if (p >= 3)
		begin
			fr = m[p-1 -: 3];
			db = 7'(6 * (SW - 2 - p));
			db = db + ((fr < 3'h2) ? 7'h05 : (fr < 3'h4) ? 7'h03 :
				(fr < 3'h6) ? 7'h02 : 7'h01);
			db = (fr == 3'h7 && db != 7'h00) ? db - 7'h01 : db;
		end
		to_db = (db > 7'(PEAK_FLOOR)) ? PEAK_FLOOR : 6'(db);
	endfunction

	logic [SW-2:0] mag_reg [2];
	wire  [SW-1:0] smp [2];
	wire  [1:0]    rd_pk = {rd_peak1_reg, rd_peak0_reg};
	assign smp[0] = ADC_LEFT_I;
	assign smp[1] = ADC_RIGHT_I;

	for (genvar c = 0; c < 2; c++)
	begin : g_peak
		// ones' complement keeps negative full scale in range
		wire [SW-2:0] mag = smp[c][SW-1] ? ~smp[c][SW-2:0]
			: smp[c][SW-2:0];
		wire          big = ADC_VALID_I & (rd_pk[c] | (mag > mag_reg[c]));
		always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
			if (!RST_B_I)
			begin
				mag_reg[c]     <= '0;
				peak_db_reg[c] <= PEAK_FLOOR;
			end
			else
			begin
				if (big)
					mag_reg[c] <= mag;
				else if (rd_pk[c])
					mag_reg[c] <= '0;
				peak_db_reg[c] <= to_db(big ? mag
					: (rd_pk[c] ? '0 : mag_reg[c]));
			end
	end

	////////////////////////////////////////////////////////////////////
	// dac serial input
	logic [SW-1:0] sr_reg [4];
	logic [7:0]    cnt_reg;
	logic          lr_reg;
	logic [SW-1:0] word_reg [8];
	logic          upd_reg;
	wire  [4:0]    wbits = (ctrl_reg.width == WID_16) ? 5'd16 :
		(ctrl_reg.width == WID_20) ? 5'd20 : 5'd24;
	wire           lr_chg = dbc_ris & (dlr_s != lr_reg);
	wire           pk_mode = ctrl_reg.packed_mode;
	wire           slot_end = pk_mode & dbc_ris & (cnt_reg[4:0] == 5'h1F);
	wire  [2:0]    pk_ch = {cnt_reg[6:5], lr_reg};

	always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
		if (!RST_B_I)
		begin
			cnt_reg <= 8'h00;
			lr_reg  <= 1'b0;
			upd_reg <= 1'b0;
		end
		else
		begin
			upd_reg <= (lr_chg & ~pk_mode) | slot_end;
			if (dbc_ris)
			begin
				lr_reg  <= dlr_s;
				cnt_reg <= lr_chg ? 8'h01 : cnt_reg + 8'h01;
			end
		end

	for (genvar p = 0; p < 4; p++)
	begin : g_pin
		// fresh bits enter the slot; capture stops after the word width
		wire take = dbc_ris & (lr_chg | (cnt_reg[4:0] < wbits));
		wire [SW-1:0] left = sr_reg[p] << (5'd24 - cnt_reg[4:0]);
		always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
			if (!RST_B_I)
				sr_reg[p] <= '0;
			else if (take)
				sr_reg[p] <= (lr_chg | (pk_mode & cnt_reg[4:0] == 5'h00))
					? {{(SW-1){1'b0}}, dpin_s[p]}
					: {sr_reg[p][SW-2:0], dpin_s[p]};
		for (genvar s = 0; s < 2; s++)
		begin : g_ch
			wire hit_n = ~pk_mode & lr_chg & (lr_reg == 1'(s));
			// packed slots arrive on pin 0 only; each channel owns its word
			wire hit_p = slot_end & (pk_ch == 3'(2*p+s));
			always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
				if (!RST_B_I)
					word_reg[2*p+s] <= '0;
				else if (init_reg)
					word_reg[2*p+s] <= '0;
				else if (hit_n)
					// full count: a 32-bit half frame wraps the slot bits
					word_reg[2*p+s] <= (cnt_reg >= 8'(wbits))
						? sr_reg[p] << (5'd24 - wbits) : left;
				else if (hit_p)
					word_reg[2*p+s] <= sr_reg[0] << (5'd24 - wbits);
		end
	end

	////////////////////////////////////////////////////////////////////
	// source select and attenuation
	wire only_one = ctrl_reg.dac_rate == RATE_192;
	for (genvar ch = 0; ch < 8; ch++)
	begin : g_out
		wire [SW-1:0] src = (ctrl_reg.replicate | only_one) & (ch > 1)
			? (ctrl_reg.replicate ? word_reg[ch % 2] : '0)
			: word_reg[ch];
		wire signed [SW+10:0] prod = $signed(src)
			* $signed({2'b00, atten_reg[ch]} + 12'd1);
		always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
			if (!RST_B_I)
				DAC_DATA_O[ch*SW +: SW] <= '0;
			else if (upd_reg)
				DAC_DATA_O[ch*SW +: SW] <= prod[SW+9:10];
	end

	always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
		if (!RST_B_I)
		begin
			DAC_VALID_O <= 1'b0;
			INIT_BUSY_O <= 1'b1;
		end
		else
		begin
			DAC_VALID_O <= upd_reg;
			INIT_BUSY_O <= init_reg;
		end
endmodule

// [verification/codec_sva.sv]
// Purpose: port assertions for codec_core
// Assumes: zero wait apb, strap held steady
// Notes:   bound into every codec_core
`timescale 1ns/1ps
module codec_sva
	import codec_pkg::*;
#(
	parameter int SW = 24
)(
	input wire logic          SYS_CLK_I,
	input wire logic          RST_B_I,
	input wire logic          PSEL_I,
	input wire logic          PENABLE_I,
	input wire logic          PWRITE_I,
	input wire logic [7:0]    PADDR_I,
	input wire logic          PREADY_O,
	input wire logic          PSLVERR_O,
	input wire logic          ADC_CLK_DIR_I,
	input wire logic          ADC_BIT_CLOCK_OE_O,
	input wire logic          ADC_FRAME_CLOCK_OE_O,
	input wire logic [8*SW-1:0] DAC_DATA_O,
	input wire logic          DAC_VALID_O,
	input wire logic          INIT_BUSY_O
);
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (!RST_B_I);
	////////////////////////////////////////////////////////////
	sequence s_acc;
		PSEL_I && PENABLE_I;
	endsequence
	sequence s_wr;
		s_acc ##0 PWRITE_I;
	endsequence
	property p_ready;
		PREADY_O;
	endproperty
	property p_init_wr;
		s_wr ##0 INIT_BUSY_O |-> PSLVERR_O;
	endproperty
	property p_unmap;
		s_acc ##0 (PADDR_I > 8'h2C) |-> PSLVERR_O;
	endproperty
	property p_peak_ro;
		s_wr ##0 (PADDR_I == ADDR_PEAK0 || PADDR_I == ADDR_PEAK1)
			|-> PSLVERR_O;
	endproperty
	property p_rd_ok;
		s_acc ##0 (!PWRITE_I && PADDR_I <= 8'h2C && PADDR_I[1:0] == 2'h0)
			|-> !PSLVERR_O;
	endproperty
	property p_oe_slave;
		ADC_CLK_DIR_I [*5] |-> !ADC_BIT_CLOCK_OE_O;
	endproperty
	property p_oe_master;
		!ADC_CLK_DIR_I [*5] |-> ADC_BIT_CLOCK_OE_O;
	endproperty
	property p_oe_pair;
		ADC_BIT_CLOCK_OE_O == ADC_FRAME_CLOCK_OE_O;
	endproperty
	property p_valid;
		DAC_VALID_O |=> !DAC_VALID_O;
	endproperty
	property p_data_hold;
		DAC_VALID_O |=> $stable(DAC_DATA_O);
	endproperty
	property p_init_once;
		!INIT_BUSY_O |=> !INIT_BUSY_O;
	endproperty
	a_ready: assert property (p_ready) else $error("pready low");
	a_init_wr: assert property (p_init_wr) else $error("init write");
	a_unmap: assert property (p_unmap) else $error("unmapped ok");
	a_peak_ro: assert property (p_peak_ro) else $error("peak wr");
	a_rd_ok: assert property (p_rd_ok) else $error("read err");
	a_oe_slave: assert property (p_oe_slave) else $error("oe on");
	a_oe_master: assert property (p_oe_master) else $error("oe off");
	a_oe_pair: assert property (p_oe_pair) else $error("oe split");
	a_valid: assert property (p_valid) else $error("valid long");
	a_data_hold: assert property (p_data_hold) else $error("data");
	a_init_once: assert property (p_init_once) else $error("busy");
endmodule
bind codec_core codec_sva #(.SW(SW)) u_sva (
	.SYS_CLK_I(SYS_CLK_I), .RST_B_I(RST_B_I), .PSEL_I(PSEL_I),
	.PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
	.PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
	.ADC_CLK_DIR_I(ADC_CLK_DIR_I), .ADC_BIT_CLOCK_OE_O(ADC_BIT_CLOCK_OE_O),
	.ADC_FRAME_CLOCK_OE_O(ADC_FRAME_CLOCK_OE_O), .DAC_DATA_O(DAC_DATA_O),
	.DAC_VALID_O(DAC_VALID_O), .INIT_BUSY_O(INIT_BUSY_O));

// [verification/dsp_model.sv]
// Purpose: serial audio source on the dac pins
// Assumes: left-justified 24-bit words, 64 bit clocks a frame, 256 packed
// Notes:   data past the word toggles every bit clock, first to the inverse of the last bit
`timescale 1ns/1ps
module dsp_model
(
	input  wire logic [23:0] word_i [8],
	input  wire logic        pk_i,
	output logic             bclk_o,
	output logic             lrclk_o,
	output logic [3:0]       sdata_o
);
	int b;
	int p;
	int len;
	initial
	begin
		bclk_o = 1'b0;
		lrclk_o = 1'b0;
		sdata_o = 4'h0;
		forever
		begin
			// mode taken at frame start so a switch never cuts a frame
			len = pk_i ? 256 : 64;
			for (b = 0; b < len; b++)
			begin
				lrclk_o = (b >= len / 2);
				for (p = 0; p < 4; p++)
				begin
					// stale bits flipped so no level passes for data
					if (b % 32 >= 24)
						sdata_o[p] = ~sdata_o[p];
					else if (len == 256)
						sdata_o[p] = word_i[2*((b%128)/32)+lrclk_o]
							[23-b%32];
					else
						sdata_o[p] = word_i[2*p+lrclk_o][23-b%32];
				end
				#80 bclk_o = 1'b1;
				#80 bclk_o = 1'b0;
			end
		end
	end
endmodule

// [verification/tb.sv]
// Purpose: self-checking bench for codec_core
// Assumes: apb master, dsp_model on the dac pins
// Notes:   expected values come from ctrl_m, word, v, db_of and fixed constants
`timescale 1ns/1ps
module tb
	import codec_pkg::*;
;
	logic clk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0, mclk = 0, dir = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata;
	logic pready, pslverr, bck, bck_oe, fck, fck_oe, av = 0, dbclk, dlr;
	logic [23:0] al = 0, ar = 0, word [8];
	logic [3:0] dsd;
	logic [191:0] ddata;
	logic dvalid, busy;
	int error_cnt = 0, samples_checked = 0, seed = 32'h9a0d, k, f, sh, n;
	logic [31:0] ctrl_m, v, a0;
	logic pk = 0;
	int sh_tab [3] = '{0, 2, 5};
	initial
		forever #5 clk = ~clk;
	initial
		forever #40 mclk = ~mclk;
	codec_core dut (.SYS_CLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel),
		.PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
		.PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.MCLK_I(mclk), .ADC_CLK_DIR_I(dir), .ADC_BIT_CLOCK_I(dbclk),
		.ADC_BIT_CLOCK_O(bck), .ADC_BIT_CLOCK_OE_O(bck_oe),
		.ADC_FRAME_CLOCK_I(dlr), .ADC_FRAME_CLOCK_O(fck),
		.ADC_FRAME_CLOCK_OE_O(fck_oe), .ADC_VALID_I(av), .ADC_LEFT_I(al),
		.ADC_RIGHT_I(ar), .DAC_BIT_CLOCK_I(dbclk), .DAC_FRAME_CLOCK_I(dlr),
		.DAC_PAIR_SERIAL_INPUT_I(dsd), .DAC_DATA_O(ddata),
		.DAC_VALID_O(dvalid), .INIT_BUSY_O(busy));
	dsp_model u_dsp (.word_i(word), .pk_i(pk), .bclk_o(dbclk), .lrclk_o(dlr),
		.sdata_o(dsd));
	////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		samples_checked++;
		if (g !== x)
		begin
			error_cnt++;
			$display("ERROR t=%0t got %h exp %h", $time, g, x);
		end
	endtask
	// peak model: 6 dB per octave below full scale plus a three-bit
	// mantissa step, floor at 63
	function automatic logic [31:0] db_of(input logic [23:0] s);
		logic [22:0] m;
		int          p;
		int          fr;
		int          d;
		m = s[23] ? ~s[22:0] : s[22:0];
		p = -1;
		for (int i = 0; i < 23; i++)
			if (m[i])
				p = i;
		if (p < 3)
			return 32'(PEAK_FLOOR);
		fr = int'(m >> (p - 3)) & 7;
		d = 6 * (22 - p) + ((fr < 2) ? 5 : (fr < 4) ? 3 :
			(fr < 6) ? 2 : (fr < 7) ? 1 : 0);
		return 32'((d > 63) ? 63 : d);
	endfunction
	task automatic acc(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [31:0] x, input logic xe);
		int c;
		c = 0;
		@(posedge clk);
		psel <= 1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1;
		@(posedge clk);
		while (pready !== 1'b1 && c < 50)
		begin
			@(posedge clk);
			c++;
		end
		if (!w)
			chk(prdata, x);
		chk(pslverr, xe);
		psel <= 0;
		pen <= 0;
	endtask
	task automatic tog(output int c, output int r);
		logic h, b;
		c = 0;
		r = 0;
		h = fck;
		b = bck;
		while (fck === h && c < 4000)
		begin
			@(posedge clk);
			c++;
			r += (bck && !b);
			b = bck;
		end
	endtask
	task automatic meas(input logic [1:0] s, input int st);
		int c, r;
		acc(1, ADDR_CTRL, 32'h08 | s, 0, 0);
		repeat (3) tog(c, r);
		chk(r, 32);
		chk((c + 8) / 16, 32 * HALF_48 / st);
	endtask
	task automatic adc(input logic [23:0] l, input logic [23:0] r);
		@(posedge clk);
		av <= 1;
		al <= l;
		ar <= r;
		@(posedge clk);
		av <= 0;
	endtask
	task automatic dac(input int sel);
		repeat (3) @(posedge dlr);
		@(negedge dlr);
		repeat (20) @(posedge clk);
		for (k = 0; k < 8; k++)
			chk(ddata[24*k +: 24], sel == 1 ? word[k%2] :
				(sel == 2 && k > 1) ? 24'h0 : word[k]);
	endtask
	task automatic give_verdict();
		$display("errors %0d checks %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		#1000000;
		error_cnt++;
		give_verdict();
	end
	initial
	begin
		for (k = 0; k < 8; k++)
			word[k] = $random(seed);
		repeat (5) @(posedge clk);
		rst_b <= 1;
		repeat (4) @(posedge clk);
		acc(0, ADDR_CTRL, 0, 32'h09, 0);
		acc(0, ADDR_STATUS, 0, 32'h203, 0);
		acc(1, ADDR_CTRL, 32'h24, 0, 1);
		for (n = 0; busy !== 1'b0 && n < 40000; n++)
			@(posedge clk);
		chk(busy, 0);
		acc(1, ADDR_STATUS, 0, 0, 1);
		acc(0, 8'h30, 0, 0, 1);
		acc(1, ADDR_PEAK0, 0, 0, 1);
		ctrl_m = 32'h09;
		foreach (sh_tab[i])
		begin
			sh = sh_tab[i];
			for (f = 0; f < 4; f++)
			begin
				v = (ctrl_m & ~(32'h3 << sh)) | (f << sh);
				acc(1, ADDR_CTRL, v, 0, f == 3);
				if (f != 3)
					ctrl_m = v;
				acc(0, ADDR_CTRL, 0, ctrl_m, 0);
			end
			acc(1, ADDR_CTRL, 32'h09, 0, 0);
			ctrl_m = 32'h09;
		end
		acc(1, ADDR_CTRL, 32'h19, 0, 0);
		acc(0, ADDR_STATUS, 0, 32'h102, 0);
		meas(SCALE_X1, STEP_X1);
		meas(SCALE_X23, STEP_X23);
		meas(SCALE_X2, STEP_X2);
		@(posedge clk);
		dir <= 1;
		repeat (8) @(posedge clk);
		acc(0, ADDR_STATUS, 0, 32'h200, 0);
		chk(bck_oe, 0);
		dir <= 0;
		for (k = 0; k < 8; k++)
		begin
			a0 = ADDR_ATTEN0 + 4 * k;
			v = $random(seed) & 32'h3FF;
			acc(0, a0, 0, ATTEN_RST, 0);
			acc(1, a0, v, 0, 0);
			acc(0, a0, 0, v, 0);
			acc(1, a0, ATTEN_RST, 0, 0);
		end
		acc(0, ADDR_PEAK0, 0, PEAK_FLOOR, 0);
		v = $random(seed) & 32'hFFFFF;
		adc(v, v);
		acc(0, ADDR_PEAK0, 0, db_of(v), 0);
		a0 = prdata;
		adc(v, v);
		acc(0, ADDR_PEAK0, 0, a0, 0);
		adc(v, v);
		adc(24'h7FFFFF, 24'h800000);
		adc(v, v);
		acc(0, ADDR_PEAK0, 0, 0, 0);
		acc(0, ADDR_PEAK1, 0, 0, 0);
		acc(0, ADDR_PEAK1, 0, PEAK_FLOOR, 0);
		dac(0);
		acc(1, ADDR_CTRL, 32'h89, 0, 0);
		dac(1);
		acc(1, ADDR_CTRL, 32'h49, 0, 0);
		dac(2);
		acc(1, ADDR_CTRL, 32'h109, 0, 0);
		pk <= 1;
		dac(0);
		give_verdict();
	end
endmodule
